// ### src/timer_buzzer_pwm_output.sv
// How it works
// - Buzzer square wave runs at half the overflow rate.
// - Buzzer enable drives the timer signal onto the pin, replacing GPIO.
// - Prescale select sits in mode bits 4..6, ignored with event clock.
// - PWM modulus from reload-select and toggle bits: 256, 64, 32, 16.
// - PWM output high while count below reference, low otherwise.
// - PWM output set high when the counter wraps at overflow, if the new reference is nonzero.
// - Duty equals active reference over selected modulus.
// - Zero reference keeps PWM output low.
// - Reference writes buffered while running, moved to active value at overflow; written straight to active while stopped.
// - Reload/reference register is write-only; whole-value writes only.
// - Overflow raises the interrupt flag in PWM mode too.
// - PWM enable drives the PWM waveform onto the pin, replacing GPIO.
// - PWM mode always reloads reference at overflow; reload-select and toggle bits pick modulus.
// - Toggle and reload bits act as such only while PWM is off.
// - Run enable is mode bit 7; clearing stops counting and outputs.
`include "timer_pwm_regs.svh"
`default_nettype none
module timer_buzzer_pwm_output
(
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Avalon-MM slave
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Interrupt
    output logic irq,
    // External event clock pin
    input wire logic eventClockPin,
    // Shared output pin
    input wire logic pinIn,
    output logic pinOut,
    output logic pinOe,
    // GPIO side of the shared pin
    input wire logic gpioOut,
    input wire logic gpioOe,
    output logic gpioIn
);
    import timer_pwm_pkg::*;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic byte_t modMask(input logic pwm, input logic aload, input logic tog);
        byte_t m;
        m = `TMR_MOD_256;
        if (pwm)
        begin
            case ({aload, tog})
                2'b00: m = `TMR_MOD_256;
                2'b01: m = `TMR_MOD_64;
                2'b10: m = `TMR_MOD_32;
                default: m = `TMR_MOD_16;
            endcase
        end
        return m;
    endfunction

    function automatic logic rateTick(input byte_t presc, input rate_t rate);
        byte_t m;
        m = 8'hff >> rate;
        return (presc & m) == m;
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    byte_t mode_r;
    byte_t count_r;
    byte_t holding_r;
    byte_t active_r;
    byte_t status_r;
    byte_t mask_r;
    byte_t presc_r;
    logic toggle_r;
    logic pwm_r;
    logic [31:0] readdata_r;
    logic waitrequest_r;
    logic irq_r;
    logic pinOut_r;
    logic pinOe_r;
    logic [1:0] syncA_r;
    logic [1:0] syncB_r;
    logic [1:0] syncC_r;
    logic [1:0] level_r;
    logic evtPrev_r;

    // ----------------------------------------
    // Decoded controls
    // ----------------------------------------
    logic runEn;
    logic pwmEn;
    logic togEn;
    logic aloadEn;
    logic extClk;
    rate_t rateSel;
    byte_t modM;
    logic access;
    logic wrLow;
    logic modeWr;
    logic cntWr;
    logic reloadWr;
    logic statusWr;
    logic maskWr;
    byte_t wByte;
    logic evtEdge;
    logic tick;
    logic ovf;
    byte_t countNxt;
    byte_t activeNxt;
    byte_t statusNxt;
    pin_func_t funcSel;

    assign runEn = mode_r[`TMR_MODE_RUN];
    assign pwmEn = mode_r[`TMR_MODE_PWM];
    assign togEn = mode_r[`TMR_MODE_TOGGLE];
    assign aloadEn = mode_r[`TMR_MODE_ALOAD];
    assign extClk = mode_r[`TMR_MODE_CKS];
    assign rateSel = mode_r[`TMR_MODE_RATE_HI:`TMR_MODE_RATE_LO];
    assign modM = modMask(pwmEn, aloadEn, togEn);
    assign access = (read || write) && waitrequest_r;
    // Write lands at the edge where the master sees waitrequest low
    assign wrLow = write && !waitrequest_r && byteenable[0];
    assign wByte = writedata[7:0];
    assign modeWr = wrLow && (address == `TMR_OFS_MODE);
    assign cntWr = wrLow && (address == `TMR_OFS_COUNT);
    assign reloadWr = wrLow && (address == `TMR_OFS_RELOAD);
    assign statusWr = wrLow && (address == `TMR_OFS_STATUS);
    assign maskWr = wrLow && (address == `TMR_OFS_MASK);

    // ----------------------------------------
    // Pin input synchronisers
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_sync
            always_ff @(posedge clock or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    syncA_r[gi] <= 1'b0;
                    syncB_r[gi] <= 1'b0;
                    syncC_r[gi] <= 1'b0;
                    level_r[gi] <= 1'b0;
                end
                else
                begin
                    syncA_r[gi] <= (gi == 0) ? eventClockPin : pinIn;
                    syncB_r[gi] <= syncA_r[gi];
                    syncC_r[gi] <= syncB_r[gi];
                    if (syncB_r[gi] == syncC_r[gi])
                        level_r[gi] <= syncC_r[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            evtPrev_r <= 1'b0;
        else
            evtPrev_r <= level_r[0];
    end

    assign evtEdge = level_r[0] && !evtPrev_r;

    // ----------------------------------------
    // Prescaler and count tick
    // ----------------------------------------
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            presc_r <= 8'h00;
        else
            presc_r <= presc_r + 8'h01;
    end

    assign tick = extClk ? evtEdge : rateTick(presc_r, rateSel);
    assign ovf = runEn && tick && ((count_r & modM) == modM);

    // ----------------------------------------
    // Counter, reload and reference
    // ----------------------------------------
    always_comb
    begin
        countNxt = count_r;
        if (cntWr)
            countNxt = wByte;
        else if (ovf)
        begin
            if (!pwmEn && aloadEn)
                countNxt = holding_r;
            else
                countNxt = 8'h00;
        end
        else if (runEn && tick)
            countNxt = (count_r + 8'h01) & modM;
    end

    always_comb
    begin
        activeNxt = active_r;
        if (ovf)
            activeNxt = holding_r;
        else if (reloadWr && !runEn)
            activeNxt = wByte;
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            count_r <= `TMR_COUNT_RST;
            holding_r <= `TMR_RELOAD_RST;
            active_r <= `TMR_RELOAD_RST;
        end
        else
        begin
            count_r <= countNxt;
            active_r <= activeNxt;
            if (reloadWr)
                holding_r <= wByte;
        end
    end

    // ----------------------------------------
    // Waveforms
    // ----------------------------------------
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            pwm_r <= 1'b0;
        else
            pwm_r <= runEn && pwmEn && ((countNxt & modM) < (activeNxt & modM));
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            toggle_r <= 1'b0;
        else if (!runEn)
            toggle_r <= 1'b0;
        else if (ovf)
            toggle_r <= ~toggle_r;
    end

    // ----------------------------------------
    // Shared pin
    // ----------------------------------------
    always_comb
    begin
        if (pwmEn)
            funcSel = FUNC_PWM;
        else if (togEn)
            funcSel = FUNC_BUZZER;
        else
            funcSel = FUNC_GPIO;
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pinOut_r <= 1'b0;
            pinOe_r <= 1'b0;
        end
        else
        begin
            case (funcSel)
                FUNC_PWM:
                begin
                    pinOut_r <= pwm_r;
                    pinOe_r <= 1'b1;
                end
                FUNC_BUZZER:
                begin
                    pinOut_r <= toggle_r;
                    pinOe_r <= 1'b1;
                end
                default:
                begin
                    pinOut_r <= gpioOut;
                    pinOe_r <= gpioOe;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Mode, status and mask registers
    // ----------------------------------------
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            mode_r <= `TMR_MODE_RST;
        else if (modeWr)
            mode_r <= wByte;
    end

    always_comb
    begin
        statusNxt = status_r;
        if (statusWr)
            statusNxt = status_r & ~wByte;
        if (ovf)
            statusNxt[`TMR_IRQ_OVF] = 1'b1;
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            status_r <= `TMR_STATUS_RST;
            mask_r <= `TMR_MASK_RST;
            irq_r <= 1'b0;
        end
        else
        begin
            status_r <= statusNxt;
            if (maskWr)
                mask_r <= wByte & 8'h01;
            irq_r <= |(statusNxt & (maskWr ? (wByte & 8'h01) : mask_r));
        end
    end

    // ----------------------------------------
    // Bus answer
    // ----------------------------------------
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            waitrequest_r <= 1'b1;
            readdata_r <= 32'h0000_0000;
        end
        else
        begin
            waitrequest_r <= !access;
            if (read && waitrequest_r)
            begin
                if (address == `TMR_OFS_MODE)
                    readdata_r <= {24'h00_0000, mode_r};
                else if (address == `TMR_OFS_COUNT)
                    readdata_r <= {24'h00_0000, count_r};
                else if (address == `TMR_OFS_STATUS)
                    readdata_r <= {24'h00_0000, status_r};
                else if (address == `TMR_OFS_MASK)
                    readdata_r <= {24'h00_0000, mask_r};
                else
                    readdata_r <= 32'h0000_0000;
            end
        end
    end

    assign readdata = readdata_r;
    assign waitrequest = waitrequest_r;
    assign irq = irq_r;
    assign pinOut = pinOut_r;
    assign pinOe = pinOe_r;
    assign gpioIn = level_r[1];

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    AST_BUZZ_TOGGLE: assert property (runEn && ovf |=> toggle_r != $past(toggle_r))
        else $error("buzzer level did not invert at overflow");
    AST_BUZZ_PIN: assert property (funcSel == FUNC_BUZZER ##1 funcSel == FUNC_BUZZER
        |=> pinOe_r && pinOut_r == $past(toggle_r))
        else $error("buzzer not driven on pin");
    AST_EXT_CLOCK: assert property (extClk && !evtEdge && !cntWr
        |=> $stable(count_r))
        else $error("event clock mode counted without an edge");
    AST_MOD_WRAP: assert property (ovf && pwmEn && !cntWr |=> count_r == 8'h00)
        else $error("pwm counter did not wrap to zero");
    AST_PWM_LEVEL: assert property (runEn && pwmEn && !modeWr
        |=> pwm_r == ((count_r & modM) < (active_r & modM)))
        else $error("pwm level disagrees with compare");
    AST_PWM_HIGH_WRAP: assert property (ovf && pwmEn && !modeWr && !cntWr
        |=> pwm_r == (($past(holding_r) & modM) != 8'h00))
        else $error("pwm not forced high at wrap");
    AST_ZERO_LOW: assert property (((active_r & modM) == 8'h00) [*2] |-> !pwm_r)
        else $error("zero reference gave high output");
    AST_HOLD_REF: assert property (runEn && !ovf |=> active_r == $past(active_r))
        else $error("active reference changed between overflows");
    AST_RELOAD_WO: assert property (read && waitrequest_r && address == `TMR_OFS_RELOAD
        |=> readdata_r == 32'h0000_0000 && !waitrequest_r)
        else $error("reload register readable");
    AST_IRQ_SET: assert property (ovf |=> status_r[`TMR_IRQ_OVF])
        else $error("overflow did not set flag");
    AST_PWM_PIN: assert property (funcSel == FUNC_PWM
        |=> pinOe_r && pinOut_r == $past(pwm_r))
        else $error("pwm not driven on pin");
    AST_PWM_RELOAD: assert property (ovf |=> active_r == $past(holding_r))
        else $error("reference not reloaded at overflow");
    AST_ALOAD_TIMER: assert property (ovf && !pwmEn && !cntWr
        |=> count_r == ($past(aloadEn) ? $past(holding_r) : 8'h00))
        else $error("timer reload mismatch");
    AST_STOP: assert property (!runEn && !cntWr
        |=> $stable(count_r) && !toggle_r && !pwm_r)
        else $error("stopped timer still active");

    COV_BUZZ: cover property (funcSel == FUNC_BUZZER && ovf ##[1:600] ovf);
    COV_PWM_WRAP: cover property (pwmEn && ovf ##1 pwm_r);
    COV_IRQ: cover property (ovf && mask_r[0] ##1 irq_r);
    COV_REF_UPDATE: cover property (runEn && reloadWr ##[1:600] ovf);
endmodule // timer_buzzer_pwm_output
`default_nettype wire

// ### src/timer_pwm_regs.svh
`ifndef TIMER_PWM_REGS_SVH
`define TIMER_PWM_REGS_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define TMR_OFS_MODE 5'h00
`define TMR_OFS_COUNT 5'h04
`define TMR_OFS_RELOAD 5'h08
`define TMR_OFS_STATUS 5'h0c
`define TMR_OFS_MASK 5'h10
// ----------------------------------------
// Mode register fields and status overflow bit
// ----------------------------------------
`define TMR_MODE_PWM 0
`define TMR_MODE_TOGGLE 1
`define TMR_MODE_ALOAD 2
`define TMR_MODE_CKS 3
`define TMR_MODE_RATE_LO 4
`define TMR_MODE_RATE_HI 6
`define TMR_MODE_RUN 7
`define TMR_IRQ_OVF 0
// ----------------------------------------
// Reset values and modulus masks
// ----------------------------------------
`define TMR_MODE_RST 8'h00
`define TMR_COUNT_RST 8'h00
`define TMR_RELOAD_RST 8'h00
`define TMR_STATUS_RST 8'h00
`define TMR_MASK_RST 8'h00
`define TMR_MOD_256 8'hff
`define TMR_MOD_64 8'h3f
`define TMR_MOD_32 8'h1f
`define TMR_MOD_16 8'h0f
`endif

// ### src/timer_pwm_pkg.sv
`default_nettype none
package timer_pwm_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [2:0] rate_t;
    typedef enum logic [1:0] {FUNC_GPIO, FUNC_BUZZER, FUNC_PWM} pin_func_t;
endpackage
`default_nettype wire

// ### tb/pin_load_model.sv
`default_nettype none
module pin_load_model
(
    // Device side of the shared pin
    input wire logic pinOut,
    input wire logic pinOe,
    // Far-side driver
    input wire logic extDrive,
    input wire logic extOe,
    // Resolved pin level
    output logic pinIn
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Pin resolution with pull-up
    // ----------------------------------------
    always_comb
    begin
        if (pinOe)
            pinIn = pinOut;
        else if (extOe)
            pinIn = extDrive;
        else
            pinIn = 1'b1;
    end
endmodule // pin_load_model
`default_nettype wire

// ### tb/test_timer_buzzer_pwm_output.sv
`include "timer_pwm_regs.svh"
`default_nettype none
module test_timer_buzzer_pwm_output import timer_pwm_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, arst_n, read, write, waitrequest, irq, eventClockPin;
    logic pinIn, pinOut, pinOe, gpioOut, gpioOe, gpioIn, extDrive, extOe;
    logic [4:0] address;
    logic [31:0] writedata, readdata;
    logic [3:0] byteenable;
    int miscompares, nTests, highs, toggles, n;
    byte_t q, c1;
    byte_t selTab[5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h03};
    int modTab[5] = '{256, 64, 32, 16, 16};
    int refTab[5] = '{30, 63, 1, 0, 15};

    timer_buzzer_pwm_output i_dut (.clock(clock), .arst_n(arst_n), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest), .irq(irq),
        .eventClockPin(eventClockPin), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
        .gpioOut(gpioOut), .gpioOe(gpioOe), .gpioIn(gpioIn));
    pin_load_model i_load (.pinOut(pinOut), .pinOe(pinOe), .extDrive(extDrive),
        .extOe(extOe), .pinIn(pinIn));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic report_and_stop();
        if (miscompares == 0 && nTests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp)
        begin
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
            miscompares++;
        end
    endtask

    task automatic access(input logic wr, input logic [4:0] a, input byte_t d,
        output byte_t rd);
        int k;
        k = 0;
        @(posedge clock);
        write <= wr;
        read <= !wr;
        address <= a;
        writedata <= {24'h000000, d};
        do
        begin
            @(posedge clock);
            k++;
        end
        while (waitrequest !== 1'b0 && k < 50);
        rd = readdata[7:0];
        write <= 1'b0;
        read <= 1'b0;
        if (k >= 50)
            check("bus answer", 32'h00000000, 32'h00000001);
    endtask

    task automatic wr(input logic [4:0] a, input byte_t d);
        byte_t dummy;
        access(1'b1, a, d, dummy);
    endtask

    task automatic measure(input int cycles);
        logic prev;
        highs = 0;
        toggles = 0;
        prev = pinOut;
        repeat (cycles)
        begin
            @(posedge clock);
            if (pinOut === 1'b1)
                highs++;
            if (pinOut !== prev)
                toggles++;
            prev = pinOut;
        end
    endtask

    task automatic setup(input byte_t mode, input byte_t cnt, input byte_t refVal);
        wr(`TMR_OFS_MODE, 8'h00);
        wr(`TMR_OFS_MASK, 8'h00);
        wr(`TMR_OFS_STATUS, 8'hff);
        wr(`TMR_OFS_MODE, mode);
        wr(`TMR_OFS_COUNT, cnt);
        wr(`TMR_OFS_RELOAD, refVal);
        wr(`TMR_OFS_MODE, mode | 8'h80);
    endtask

    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    initial
    begin
        repeat (40000) @(posedge clock);
        miscompares++;
        report_and_stop();
    end

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial
    begin
        arst_n = 1'b0;
        read = 1'b0;
        write = 1'b0;
        address = 5'h00;
        writedata = 32'h00000000;
        byteenable = 4'hf;
        eventClockPin = 1'b0;
        gpioOut = 1'b0;
        gpioOe = 1'b0;
        extDrive = 1'b0;
        extOe = 1'b0;
        repeat (10) @(posedge clock);
        arst_n <= 1'b1;
        for (int i = 0; i < 5; i++)
        begin
            access(1'b0, 5'(i * 4), 8'h00, q);
            check("reset value", q, 8'h00);
        end
        wr(`TMR_OFS_RELOAD, 8'h5a);
        access(1'b0, `TMR_OFS_RELOAD, 8'h00, q);
        check("reload reads zero", q, 8'h00);
        wr(5'h14, 8'hff);
        access(1'b0, 5'h14, 8'h00, q);
        check("unmapped read", q, 8'h00);
        gpioOe <= 1'b1;
        repeat (3) @(posedge clock);
        check("gpio drive enable", pinOe, 1'b1);
        check("gpio drive value", pinOut, 1'b0);
        gpioOe <= 1'b0;
        extOe <= 1'b1;
        repeat (10) @(posedge clock);
        check("gpio input low", gpioIn, 1'b0);
        extDrive <= 1'b1;
        repeat (10) @(posedge clock);
        check("gpio input high", gpioIn, 1'b1);
        extOe <= 1'b0;
        gpioOut <= 1'b1;
        for (int i = 0; i < 5; i++)
        begin
            setup(8'h71 | (selTab[i] << 1), 8'h00, 8'(refTab[i]));
            repeat (modTab[i] * 2 + 8) @(posedge clock);
            check("pwm drive enable", pinOe, 1'b1);
            measure(modTab[i] * 4);
            check("pwm high clocks", highs, refTab[i] * 4);
            check("pwm edges", toggles, (refTab[i] > 0) ? 4 : 0);
        end
        setup(8'h77, 8'h00, 8'd12);
        wr(`TMR_OFS_MASK, 8'h01);
        wr(`TMR_OFS_STATUS, 8'h01);
        n = 0;
        while (irq !== 1'b1 && n < 100)
        begin
            @(posedge clock);
            n++;
        end
        check("irq in pwm mode", irq, 1'b1);
        wr(`TMR_OFS_STATUS, 8'h01);
        wr(`TMR_OFS_RELOAD, 8'd3);
        measure(16);
        check("old duty kept", highs > 10, 1'b1);
        repeat (32) @(posedge clock);
        measure(64);
        check("new duty", highs, 12);
        wr(`TMR_OFS_MASK, 8'h00);
        wr(`TMR_OFS_STATUS, 8'h01);
        repeat (40) @(posedge clock);
        access(1'b0, `TMR_OFS_STATUS, 8'h00, q);
        check("overflow flag", q, 8'h01);
        check("masked irq", irq, 1'b0);
        wr(`TMR_OFS_MODE, 8'h77);
        repeat (4) @(posedge clock);
        check("stopped pin", pinOut, 1'b0);
        access(1'b0, `TMR_OFS_COUNT, 8'h00, c1);
        repeat (20) @(posedge clock);
        access(1'b0, `TMR_OFS_COUNT, 8'h00, q);
        check("count halted", q, c1);
        setup(8'h76, 8'hf0, 8'hf0);
        repeat (2) @(posedge clock);
        check("buzzer starts low", pinOut, 1'b0);
        check("buzzer drive enable", pinOe, 1'b1);
        measure(640);
        check("buzzer edges", toggles, 20);
        check("buzzer high clocks", highs, 320);
        setup(8'h78, 8'h00, 8'h00);
        repeat (5)
        begin
            eventClockPin <= 1'b1;
            repeat (8) @(posedge clock);
            eventClockPin <= 1'b0;
            repeat (8) @(posedge clock);
        end
        repeat (8) @(posedge clock);
        access(1'b0, `TMR_OFS_COUNT, 8'h00, q);
        check("event count", q, 8'h05);
        setup(8'h40, 8'h00, 8'h00);
        repeat (80) @(posedge clock);
        access(1'b0, `TMR_OFS_COUNT, 8'h00, q);
        check("prescaled count", (q == 8'd5) || (q == 8'd6), 1'b1);
        report_and_stop();
    end
endmodule // test_timer_buzzer_pwm_output
`default_nettype wire
